// File: flash_region_check.sv
// Package of shared constants and types, and the region permission check.
// Assumes requests and protection flags come from logic on the same clock.
`default_nettype none

package flash_prot_pkg;
  // ****************************************************************
  // Sizes and values
  // ****************************************************************
  localparam int FLASH_BYTES = 131072;
  localparam int UNIT_BYTES = 1024;
  localparam int REGION_BYTES = 2048;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 32;
  localparam int WORD_BYTES = 4;
  localparam logic [31:0] ERASED_WORD = 32'hFFFFFFFF;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {OP_READ, OP_PROGRAM, OP_ERASE} op_t;
  typedef enum logic [1:0] {SRC_FETCH, SRC_DATA, SRC_DEBUG} src_t;
  typedef enum logic {PH_IDLE, PH_ERASE} phase_t;

  typedef struct packed {
    logic valid;
    op_t op;
    src_t src;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } req_t;

  typedef struct packed {
    logic valid;
    logic denied;
    logic [DATA_W-1:0] data;
  } resp_t;

  // Returns the protection region that holds a byte address.
  function automatic logic [ADDR_W-1:0] region_of(
    input logic [ADDR_W-1:0] addr, input int shift);
    region_of = addr >> shift;
  endfunction
endpackage

module flash_region_check #(
  parameter int FLASH_BYTES = flash_prot_pkg::FLASH_BYTES,
  parameter int REGION_BYTES = flash_prot_pkg::REGION_BYTES,
  localparam int REGIONS = FLASH_BYTES / REGION_BYTES,
  localparam int RW = $clog2(REGIONS)
) (
  input var flash_prot_pkg::req_t req,
  input wire logic [REGIONS-1:0] ro_flags,
  input wire logic [REGIONS-1:0] xo_flags,
  output logic allow
);
  logic [flash_prot_pkg::ADDR_W-1:0] region;
  logic in_range;
  logic ro;
  logic xo;

  assign region = flash_prot_pkg::region_of(req.addr, $clog2(REGION_BYTES));
  assign in_range = 32'(req.addr) < FLASH_BYTES;
  assign ro = in_range && ro_flags[region[RW-1:0]];
  assign xo = in_range && xo_flags[region[RW-1:0]];

  always_comb begin
    case (req.op)
      flash_prot_pkg::OP_READ:
        allow = in_range &&
          (!xo || req.src == flash_prot_pkg::SRC_FETCH);
      flash_prot_pkg::OP_PROGRAM,
      flash_prot_pkg::OP_ERASE:
        allow = in_range && !ro && !xo;
      default:
        allow = 1'b0;
    endcase
  end
endmodule

`default_nettype wire

// File: flash_block_protection.sv
// Flash array with block erase, programming and region protection.
// Assumes protection flags are held by same-clock logic outside.
//
// Contract
// - Decode and serve the whole 128 KB flash range.
// - Erase in independent 1 KB units.
// - An erased unit reads back as all ones.
// - Protection applies per 2 KB region of two adjacent units.
// - Read-only regions refuse every erase and program.
// - Execute-only regions refuse every erase and program.
// - Execute-only regions return data to instruction fetch only.
`default_nettype none

module flash_block_protection #(
  parameter int FLASH_BYTES = flash_prot_pkg::FLASH_BYTES,
  parameter int UNIT_BYTES = flash_prot_pkg::UNIT_BYTES,
  parameter int REGION_BYTES = flash_prot_pkg::REGION_BYTES,
  localparam int REGIONS = FLASH_BYTES / REGION_BYTES,
  localparam int RW = $clog2(REGIONS),
  localparam int AW = $clog2(FLASH_BYTES),
  localparam int WA = AW - 2,
  localparam int UW = $clog2(UNIT_BYTES / flash_prot_pkg::WORD_BYTES),
  localparam int NW = WA - UW
) (
  input wire logic clk,
  input wire logic rst,
  input var flash_prot_pkg::req_t req,
  input wire logic [REGIONS-1:0] ro_flags,
  input wire logic [REGIONS-1:0] xo_flags,
  output var logic busy,
  output var flash_prot_pkg::resp_t resp
);
  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  if (REGION_BYTES != 2 * UNIT_BYTES || REGIONS < 2 ||
      FLASH_BYTES % REGION_BYTES != 0 ||
      FLASH_BYTES > 2 ** flash_prot_pkg::ADDR_W ||
      (1 << AW) != FLASH_BYTES || (1 << (UW + 2)) != UNIT_BYTES ||
      UW < 1) begin : bad_params
    $error("Unsupported flash geometry.");
  end

  // ****************************************************************
  // State and storage
  // ****************************************************************
  typedef struct packed {
    flash_prot_pkg::phase_t phase;
    logic [UW-1:0] cnt;
    logic [NW-1:0] unit;
    logic busy;
    flash_prot_pkg::resp_t resp;
  } state_t;

  state_t st;
  state_t next_st;
  logic [flash_prot_pkg::DATA_W-1:0] mem [2**WA];
  logic mem_we;
  logic [WA-1:0] mem_waddr;
  logic [flash_prot_pkg::DATA_W-1:0] mem_wdata;
  logic allow;
  logic [WA-1:0] word;

  assign word = req.addr[AW-1:2];

  flash_region_check #(
    .FLASH_BYTES(FLASH_BYTES),
    .REGION_BYTES(REGION_BYTES)
  ) check (
    .req(req),
    .ro_flags(ro_flags),
    .xo_flags(xo_flags),
    .allow(allow)
  );

  // ****************************************************************
  // Request handling and erase sequencing
  // ****************************************************************
  always_comb begin
    next_st = st;
    next_st.resp.valid = 1'b0;
    mem_we = 1'b0;
    mem_waddr = '0;
    mem_wdata = '0;
    case (st.phase)
      flash_prot_pkg::PH_IDLE: begin
        if (req.valid) begin
          next_st.resp.valid = 1'b1;
          next_st.resp.denied = !allow;
          next_st.resp.data = '0;
          case (req.op)
            flash_prot_pkg::OP_READ: begin
              if (allow) begin
                next_st.resp.data = mem[word];
              end
            end
            flash_prot_pkg::OP_PROGRAM: begin
              if (allow) begin
                mem_we = 1'b1;
                mem_waddr = word;
                mem_wdata = mem[word] & req.wdata;
              end
            end
            flash_prot_pkg::OP_ERASE: begin
              if (allow) begin
                next_st.resp.valid = 1'b0;
                next_st.phase = flash_prot_pkg::PH_ERASE;
                next_st.busy = 1'b1;
                next_st.cnt = '0;
                next_st.unit = req.addr[AW-1:AW-NW];
              end
            end
            default: begin
              next_st.resp.denied = 1'b1;
            end
          endcase
        end
      end
      flash_prot_pkg::PH_ERASE: begin
        mem_we = 1'b1;
        mem_waddr = {st.unit, st.cnt};
        mem_wdata = flash_prot_pkg::ERASED_WORD;
        next_st.cnt = st.cnt + 1'b1;
        if (&st.cnt) begin
          next_st.phase = flash_prot_pkg::PH_IDLE;
          next_st.busy = 1'b0;
          next_st.resp.valid = 1'b1;
          next_st.resp.denied = 1'b0;
          next_st.resp.data = '0;
        end
      end
      default: begin
        next_st = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  assign busy = st.busy;
  assign resp = st.resp;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic take;
  logic [flash_prot_pkg::ADDR_W-1:0] a_region;
  logic ro_hit;
  logic xo_hit;
  logic change;

  assign take = req.valid && !st.busy;
  assign a_region = flash_prot_pkg::region_of(req.addr, $clog2(REGION_BYTES));
  assign ro_hit = ro_flags[a_region[RW-1:0]];
  assign xo_hit = xo_flags[a_region[RW-1:0]];
  assign change = req.op != flash_prot_pkg::OP_READ;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_fetch_served: assert property (
    take && req.op == flash_prot_pkg::OP_READ &&
    req.src == flash_prot_pkg::SRC_FETCH |=> resp.valid && !resp.denied)
    else $error("Fetch read not served.");

  a_erase_length: assert property (
    take && req.op == flash_prot_pkg::OP_ERASE && allow
    |=> busy [*8] ##248 busy ##1 !busy && resp.valid && !resp.denied)
    else $error("Erase did not take one unit of words.");

  a_erase_ones: assert property (
    st.phase == flash_prot_pkg::PH_ERASE |->
    mem_we && mem_wdata == flash_prot_pkg::ERASED_WORD &&
    mem_waddr[WA-1:UW] == st.unit ##1
    mem[$past(mem_waddr)] == flash_prot_pkg::ERASED_WORD)
    else $error("Erase wrote a word other than all ones.");

  a_region_pair: assert property (
    take && req.op == flash_prot_pkg::OP_PROGRAM
    |=> resp.valid && resp.denied == $past(ro_hit || xo_hit))
    else $error("Program refusal does not follow region flags.");

  a_ro_refuse: assert property (
    take && change && ro_hit |-> !mem_we ##1
    resp.valid && resp.denied && !busy)
    else $error("Read-only region was modified.");

  a_xo_refuse: assert property (
    take && change && xo_hit |-> !mem_we ##1
    resp.valid && resp.denied && !busy)
    else $error("Execute-only region was modified.");

  a_xo_read_block: assert property (
    take && req.op == flash_prot_pkg::OP_READ && xo_hit &&
    req.src != flash_prot_pkg::SRC_FETCH
    |=> resp.valid && resp.denied && resp.data == '0)
    else $error("Execute-only data leaked to a non-fetch read.");

  a_open_region: assert property (
    take && !ro_hit && !xo_hit &&
    (req.op == flash_prot_pkg::OP_READ ||
    req.op == flash_prot_pkg::OP_PROGRAM)
    |=> resp.valid && !resp.denied)
    else $error("Unprotected region access was refused.");

  a_ro_fetch_read: assert property (
    take && req.op == flash_prot_pkg::OP_READ && ro_hit && !xo_hit
    |=> resp.valid && !resp.denied)
    else $error("Read-only region refused a read.");
endmodule

`default_nettype wire

// File: flash_block_protection_end.sv
`default_nettype none
`default_nettype wire

// File: flash_requester.sv
// Requester model for the fetch, data and debug paths.
// Assumes the protection block runs on the same clock.
`default_nettype none

module flash_requester (
  input wire logic clk,
  output var flash_prot_pkg::req_t req
);
  timeunit 1ns;
  timeprecision 1ps;

  initial req = '0;

  // Holds one request for a single edge, then scrambles the lines.
  task automatic issue(input flash_prot_pkg::op_t op,
    input flash_prot_pkg::src_t src, input logic [16:0] a,
    input logic [31:0] w);
    @(posedge clk);
    req <= '{1'h1, op, src, a, w};
    @(posedge clk);
    req <= '{1'h0, op, src, ~a, ~w};
  endtask
endmodule

`default_nettype wire

// File: flash_block_protection_tb.sv
// Testbench for the flash protection block.
// Assumes the requester model drives the request port.
`default_nettype none

module flash_block_protection_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [63:0] ro_flags = '0;
  logic [63:0] xo_flags = '0;
  logic busy;
  flash_prot_pkg::req_t req;
  flash_prot_pkg::resp_t resp;
  int n_mismatch = 0;
  int samples_checked = 0;

  always #4 clk = ~clk;

  flash_requester i_host (.clk(clk), .req(req));

  flash_block_protection i_dut (.clk(clk), .rst(rst), .req(req),
    .ro_flags(ro_flags), .xo_flags(xo_flags), .busy(busy), .resp(resp));

  task automatic chk(input string name, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic xfer(input flash_prot_pkg::op_t op,
    input flash_prot_pkg::src_t s, input logic [16:0] a,
    input logic [31:0] w, input logic d, input logic [31:0] v);
    int n;
    logic [31:0] exp_n;
    i_host.issue(op, s, a, w);
    #1;
    n = 1;
    if (op == flash_prot_pkg::OP_ERASE) chk("busy", busy, !d);
    while (resp.valid !== 1'h1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    exp_n = (op == flash_prot_pkg::OP_ERASE && !d) ? 32'h101 : 32'h1;
    chk("latency", 32'(n), exp_n);
    chk("idle", busy, 1'h0);
    chk("denied", resp.denied, d);
    chk("data", resp.data, v);
  endtask

  task automatic rd(input flash_prot_pkg::src_t s, input logic [16:0] a,
    input logic d, input logic [31:0] v);
    xfer(flash_prot_pkg::OP_READ, s, a, 32'h0, d, v);
  endtask

  task automatic pg(input logic [16:0] a, input logic [31:0] w,
    input logic d);
    xfer(flash_prot_pkg::OP_PROGRAM, flash_prot_pkg::SRC_DATA, a, w, d,
      32'h0);
  endtask

  task automatic er(input logic [16:0] a, input logic d);
    xfer(flash_prot_pkg::OP_ERASE, flash_prot_pkg::SRC_DATA, a, 32'h0, d,
      32'h0);
  endtask

  task automatic t_free();
    er(17'h00000, 1'h0);
    rd(flash_prot_pkg::SRC_DATA, 17'h003FC, 1'h0, 32'hFFFFFFFF);
    pg(17'h00004, 32'h12345678, 1'h0);
    er(17'h00400, 1'h0);
    rd(flash_prot_pkg::SRC_DEBUG, 17'h00004, 1'h0, 32'h12345678);
    pg(17'h00004, 32'hFF00FF00, 1'h0);
    rd(flash_prot_pkg::SRC_DATA, 17'h00004, 1'h0, 32'h12005600);
    $display("test free done");
  endtask

  task automatic t_ro();
    er(17'h00C00, 1'h0);
    @(posedge clk) ro_flags[1] <= 1'h1;
    pg(17'h00C00, 32'h0, 1'h1);
    er(17'h00800, 1'h1);
    rd(flash_prot_pkg::SRC_DEBUG, 17'h00C00, 1'h0, 32'hFFFFFFFF);
    $display("test read-only done");
  endtask

  task automatic t_xo();
    er(17'h1FC00, 1'h0);
    @(posedge clk) xo_flags[63] <= 1'h1;
    rd(flash_prot_pkg::SRC_FETCH, 17'h1FFFC, 1'h0, 32'hFFFFFFFF);
    rd(flash_prot_pkg::SRC_DATA, 17'h1FFFC, 1'h1, 32'h0);
    rd(flash_prot_pkg::SRC_DEBUG, 17'h1FFFC, 1'h1, 32'h0);
    pg(17'h1FC00, 32'h0, 1'h1);
    er(17'h1F800, 1'h1);
    er(17'h1F400, 1'h0);
    rd(flash_prot_pkg::SRC_FETCH, 17'h1FC00, 1'h0, 32'hFFFFFFFF);
    $display("test execute-only done");
  endtask

  task automatic t_rst();
    flash_prot_pkg::op_t bad;
    bad = flash_prot_pkg::op_t'(2'h3);
    i_host.issue(flash_prot_pkg::OP_ERASE, flash_prot_pkg::SRC_DATA,
      17'h01000, 32'h0);
    repeat (3) @(posedge clk);
    rst <= 1'h1;
    @(posedge clk);
    rst <= 1'h0;
    #1;
    chk("rst busy", busy, 1'h0);
    chk("rst valid", resp.valid, 1'h0);
    rd(flash_prot_pkg::SRC_DEBUG, 17'h00004, 1'h0, 32'h12005600);
    xfer(bad, flash_prot_pkg::SRC_DATA, 17'h4, 32'h0, 1'h1, 32'h0);
    $display("test reset done");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    t_free();
    t_ro();
    t_xo();
    t_rst();
    summarize();
  end

  // About 1340 cycles are needed; the limit leaves wide margin.
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
endmodule

`default_nettype wire
